//--- adcc_defines.svh
// constants of the a/d conversion control block: offsets, fields, resets, timing
// assumes one 10 MHz clock and an apb master with 32-bit data
`ifndef ADCC_DEFINES_SVH
`define ADCC_DEFINES_SVH

// ********************************************************
// register indices and byte addresses
// ********************************************************
`define ADCC_IDX_PORT_A 12'h005
`define ADCC_IDX_IRQ_STATUS 12'h00C
`define ADCC_IDX_RESULT 12'h01E
`define ADCC_IDX_CONTROL 12'h01F
`define ADCC_IDX_PORT_A_DIR 12'h085
`define ADCC_IDX_IRQ_MASK 12'h08C
`define ADCC_IDX_PIN_CONFIG 12'h09F
`define ADCC_ADDR_PORT_A 12'h014
`define ADCC_ADDR_IRQ_STATUS 12'h030
`define ADCC_ADDR_RESULT 12'h078
`define ADCC_ADDR_CONTROL 12'h07C
`define ADCC_ADDR_PORT_A_DIR 12'h214
`define ADCC_ADDR_IRQ_MASK 12'h230
`define ADCC_ADDR_PIN_CONFIG 12'h27C

// ********************************************************
// fields and reset values
// ********************************************************
`define ADCC_CTL_CLKSEL_HI 7
`define ADCC_CTL_CLKSEL_LO 6
`define ADCC_CTL_CHAN_HI 5
`define ADCC_CTL_CHAN_LO 3
`define ADCC_CTL_GO 2
`define ADCC_CTL_POWER 0
`define ADCC_IRQ_DONE 6
`define ADCC_IRQ_GLOBAL 7
`define ADCC_CONTROL_RST 8'h00
`define ADCC_PIN_CONFIG_RST 3'h0
`define ADCC_PORT_DIR_RST 6'h3F
`define ADCC_TRIAL_RST 8'h80

// ********************************************************
// timing
// ********************************************************
`define ADCC_CLOCK_PERIOD_NS 100
`define ADCC_TAD_MIN_NS 1600
`define ADCC_RC_TAD_TYP_NS 4000
`define ADCC_TOSC_DIV0 2
`define ADCC_TOSC_DIV1 8
`define ADCC_TOSC_DIV2 32
`define ADCC_RC_HALF_CYCLES (`ADCC_RC_TAD_TYP_NS / `ADCC_CLOCK_PERIOD_NS / 2)
`define ADCC_SAMPLE_HALVES 3
`define ADCC_LAST_HALF 18

`endif

//--- adcc_pkg.sv
// types of the a/d conversion control block
// assumes adcc_defines.svh for all numeric constants
package adcc_pkg;

  typedef enum logic [1:0] {
    ADCC_IDLE,
    ADCC_SAMPLE,
    ADCC_BITS
  } adcc_state_t;

  typedef enum logic [1:0] {
    ADCC_CLK_TOSC2,
    ADCC_CLK_TOSC8,
    ADCC_CLK_TOSC32,
    ADCC_CLK_RC
  } adcc_clksel_t;

endpackage

//--- adcc_sync.sv
// two-flop synchroniser for asynchronous levels
// assumes inputs come from pins or analog comparators
`timescale 1ns/10ps
`default_nettype none

module adcc_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] meta_q;

  initial begin
    if (WIDTH < 1) $error("adcc_sync: WIDTH must be at least 1");
  end

  // first stage feeds only the second
  always_ff @(posedge clock) begin
    if (rst) begin
      meta_q <= '0;
      syncOut <= '0;
    end else begin
      meta_q <= asyncIn;
      syncOut <= meta_q;
    end
  end

endmodule
`default_nettype wire

//--- adcc_tad_timer.sv
// half bit-period tick generator for the conversion clock
// assumes restart pulses when a conversion starts
`timescale 1ns/10ps
`default_nettype none
`include "adcc_defines.svh"

module adcc_tad_timer #(
  parameter int CNT_W = 6
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic restart,
  input wire logic [1:0] clockSelect,
  input wire logic sleepMode,
  output logic halfTick
);

  logic [CNT_W-1:0] count_q;
  logic [CNT_W-1:0] halfLen;
  logic running;

  initial begin
    if ((1 << CNT_W) <= `ADCC_RC_HALF_CYCLES) $error("adcc_tad_timer: CNT_W too small");
  end

  always_comb begin
    case (adcc_pkg::adcc_clksel_t'(clockSelect))
      adcc_pkg::ADCC_CLK_TOSC2: halfLen = CNT_W'(`ADCC_TOSC_DIV0 / 2);
      adcc_pkg::ADCC_CLK_TOSC8: halfLen = CNT_W'(`ADCC_TOSC_DIV1 / 2);
      adcc_pkg::ADCC_CLK_TOSC32: halfLen = CNT_W'(`ADCC_TOSC_DIV2 / 2);
      default: halfLen = CNT_W'(`ADCC_RC_HALF_CYCLES);
    endcase
  end

  // oscillator-derived sources stop in sleep, only rc keeps going
  assign running = !sleepMode || (clockSelect == 2'(adcc_pkg::ADCC_CLK_RC));
  assign halfTick = running && !restart && (count_q == halfLen - CNT_W'(1));

  always_ff @(posedge clock) begin
    if (rst || restart) begin
      count_q <= '0;
    end else if (halfTick) begin
      count_q <= '0;
    end else if (running) begin
      count_q <= count_q + CNT_W'(1);
    end
  end

endmodule
`default_nettype wire

//--- adcc_conversion_control.sv
// a/d conversion control: apb registers, port a view, sar sequencer, done irq
// assumes an analog comparator, dac and channel mux outside, driven from the
// trial code, channel select and hold switch outputs of this block
`timescale 1ns/10ps
`default_nettype none
`include "adcc_defines.svh"

module adcc_conversion_control #(
  parameter int ADDR_W = 12,
  parameter int PORT_W = 6
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire logic sleepMode,
  input wire logic compAboveIn,
  input wire logic [PORT_W-1:0] portPinIn,
  output logic [PORT_W-1:0] portPinOut,
  output logic [PORT_W-1:0] portPinOe,
  output logic [2:0] channelSelect,
  output logic holdCapDisconnect,
  output logic [7:0] dacTrial,
  output logic converterPowered
);

  // ********************************************************
  // elaboration checks
  // ********************************************************
  initial begin
    if (ADDR_W < 10) $error("adcc_conversion_control: ADDR_W below 10");
    if (PORT_W != 6) $error("adcc_conversion_control: PORT_W must be 6");
    if (`ADCC_SAMPLE_HALVES < 1) $error("adcc_conversion_control: no settling half periods");
    if (`ADCC_LAST_HALF != `ADCC_SAMPLE_HALVES + 15) $error("adcc_conversion_control: last half mismatch");
  end

  // ********************************************************
  // declarations
  // ********************************************************
  logic [7:0] control_q;
  logic [2:0] pinConfig_q;
  logic [PORT_W-1:0] portLatch_q;
  logic [PORT_W-1:0] portDir_q;
  logic doneFlag_q;
  logic doneMask_q;
  logic globalEn_q;
  logic [7:0] result_q;
  logic [7:0] trial_q;
  logic [7:0] bitMask_q;
  logic [4:0] halfCnt_q;
  adcc_pkg::adcc_state_t state_q;

  logic [PORT_W-1:0] pinSync;
  logic compSync;
  logic halfTick;
  logic wrAccess;
  logic setupRead;
  logic hitMapped;
  logic startConv;
  logic abortConv;
  logic finishConv;
  logic decideTick;
  logic inputAbove;
  logic [4:0] analogMask;
  logic [PORT_W-1:0] analogPins;
  logic [2:0] selPin;
  logic selPinValid;
  logic [7:0] keptTrial;
  logic [31:0] readData;

  // ********************************************************
  // synchronisers and conversion clock
  // ********************************************************
  adcc_sync #(
    .WIDTH(PORT_W)
  ) u_pinSync (
    .clock(clock),
    .rst(rst),
    .asyncIn(portPinIn),
    .syncOut(pinSync)
  );

  // two-cycle lag is harmless while the bit period holds 16 cycles or more
  adcc_sync #(
    .WIDTH(1)
  ) u_compSync (
    .clock(clock),
    .rst(rst),
    .asyncIn(compAboveIn),
    .syncOut(compSync)
  );

  // rc period is a fixed divide of clock, without the spread a real rc shows
  adcc_tad_timer #(
    .CNT_W(6)
  ) u_tadTimer (
    .clock(clock),
    .rst(rst),
    .restart(startConv),
    .clockSelect(control_q[`ADCC_CTL_CLKSEL_HI:`ADCC_CTL_CLKSEL_LO]),
    .sleepMode(sleepMode),
    .halfTick(halfTick)
  );

  // ********************************************************
  // apb decode
  // ********************************************************
  assign wrAccess = psel && penable && pwrite;
  assign setupRead = psel && !penable && !pwrite;
  assign pready = psel && penable;
  assign pslverr = psel && penable && !hitMapped;

  always_comb begin
    readData = 32'h0000_0000;
    hitMapped = 1'b1;
    if (paddr == ADDR_W'(`ADCC_ADDR_CONTROL)) begin
      readData[7:0] = control_q;
    end else if (paddr == ADDR_W'(`ADCC_ADDR_RESULT)) begin
      readData[7:0] = result_q;
    end else if (paddr == ADDR_W'(`ADCC_ADDR_PIN_CONFIG)) begin
      readData[2:0] = pinConfig_q;
    end else if (paddr == ADDR_W'(`ADCC_ADDR_PORT_A)) begin
      readData[PORT_W-1:0] = pinSync & ~analogPins;
    end else if (paddr == ADDR_W'(`ADCC_ADDR_PORT_A_DIR)) begin
      readData[PORT_W-1:0] = portDir_q;
    end else if (paddr == ADDR_W'(`ADCC_ADDR_IRQ_STATUS)) begin
      readData[`ADCC_IRQ_DONE] = doneFlag_q;
    end else if (paddr == ADDR_W'(`ADCC_ADDR_IRQ_MASK)) begin
      readData[`ADCC_IRQ_DONE] = doneMask_q;
      readData[`ADCC_IRQ_GLOBAL] = globalEn_q;
    end else begin
      hitMapped = 1'b0;
    end
  end

  // read data captured in setup so the access phase answers from a flop
  // costs a flop stage but keeps prdata steady through the access phase
  always_ff @(posedge clock) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (setupRead) begin
      prdata <= readData;
    end
  end

  // ********************************************************
  // pin configuration and port a
  // ********************************************************
  // an0..an3 sit on ra0..ra3, an4 on ra5
  always_comb begin
    case (pinConfig_q)
      3'h0: analogMask = 5'h1F;
      3'h1: analogMask = 5'h0F;
      3'h2: analogMask = 5'h07;
      3'h3: analogMask = 5'h03;
      3'h4: analogMask = 5'h01;
      default: analogMask = 5'h00;
    endcase
  end

  assign analogPins = {analogMask[4], 1'b0, analogMask[3:0]};

  always_ff @(posedge clock) begin
    if (rst) begin
      pinConfig_q <= `ADCC_PIN_CONFIG_RST;
    end else if (wrAccess && paddr == ADDR_W'(`ADCC_ADDR_PIN_CONFIG)) begin
      pinConfig_q <= pwdata[2:0];
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      portDir_q <= `ADCC_PORT_DIR_RST;
    end else if (wrAccess && paddr == ADDR_W'(`ADCC_ADDR_PORT_A_DIR)) begin
      portDir_q <= pwdata[PORT_W-1:0];
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      portLatch_q <= '0;
    end else if (wrAccess && paddr == ADDR_W'(`ADCC_ADDR_PORT_A)) begin
      portLatch_q <= pwdata[PORT_W-1:0];
    end
  end

  // direction bit clear means the pin is driven, analog or not
  assign portPinOut = portLatch_q;
  assign portPinOe = ~portDir_q;

  // ********************************************************
  // control register
  // ********************************************************
  assign startConv = wrAccess && paddr == ADDR_W'(`ADCC_ADDR_CONTROL) && pwdata[`ADCC_CTL_GO]
    && pwdata[`ADCC_CTL_POWER] && control_q[`ADCC_CTL_POWER] && (state_q == adcc_pkg::ADCC_IDLE);
  // clearing go or power mid-conversion drops it without a result
  assign abortConv = wrAccess && paddr == ADDR_W'(`ADCC_ADDR_CONTROL)
    && (!pwdata[`ADCC_CTL_GO] || !pwdata[`ADCC_CTL_POWER]);

  always_ff @(posedge clock) begin
    if (rst) begin
      control_q <= `ADCC_CONTROL_RST;
    end else if (finishConv) begin
      // a control write landing with the last decision keeps its fields, not go
      if (wrAccess && paddr == ADDR_W'(`ADCC_ADDR_CONTROL)) begin
        control_q <= {pwdata[7:3], 1'b0, 1'b0, pwdata[0]};
      end else begin
        control_q[`ADCC_CTL_GO] <= 1'b0;
      end
    end else if (wrAccess && paddr == ADDR_W'(`ADCC_ADDR_CONTROL)) begin
      control_q <= {pwdata[7:3], startConv || (control_q[`ADCC_CTL_GO] && !abortConv), 1'b0, pwdata[0]};
    end
  end

  assign channelSelect = control_q[`ADCC_CTL_CHAN_HI:`ADCC_CTL_CHAN_LO];
  assign converterPowered = control_q[`ADCC_CTL_POWER];

  // ********************************************************
  // sar sequencer
  // ********************************************************
  // neither the channel nor the direction bits stop a running conversion
  always_comb begin
    selPinValid = 1'b1;
    case (channelSelect)
      3'h0: selPin = 3'h0;
      3'h1: selPin = 3'h1;
      3'h2: selPin = 3'h2;
      3'h3: selPin = 3'h3;
      3'h4: selPin = 3'h5;
      default: begin
        selPin = 3'h0;
        selPinValid = 1'b0;
      end
    endcase
  end

  // driven pin: its digital level is full scale or zero
  // input pin: comparator sees the analog level even if digital
  always_comb begin
    if (selPinValid && !portDir_q[selPin]) begin
      inputAbove = portLatch_q[selPin];
    end else begin
      inputAbove = compSync;
    end
  end

  assign decideTick = halfTick && (state_q == adcc_pkg::ADCC_BITS) && !halfCnt_q[0];
  assign finishConv = decideTick && (halfCnt_q == 5'(`ADCC_LAST_HALF)) && !abortConv;
  assign keptTrial = inputAbove ? trial_q : (trial_q & ~bitMask_q);

  always_ff @(posedge clock) begin
    if (rst || abortConv) begin
      state_q <= adcc_pkg::ADCC_IDLE;
    end else begin
      case (state_q)
        adcc_pkg::ADCC_IDLE: begin
          if (startConv) begin
            state_q <= adcc_pkg::ADCC_SAMPLE;
          end
        end
        adcc_pkg::ADCC_SAMPLE: begin
          if (halfTick && halfCnt_q == 5'(`ADCC_SAMPLE_HALVES - 1)) begin
            state_q <= adcc_pkg::ADCC_BITS;
          end
        end
        adcc_pkg::ADCC_BITS: begin
          if (finishConv) begin
            state_q <= adcc_pkg::ADCC_IDLE;
          end
        end
        default: state_q <= adcc_pkg::ADCC_IDLE;
      endcase
    end
  end

  // nineteen half periods in all: three of settling, two per bit
  always_ff @(posedge clock) begin
    if (rst || startConv) begin
      halfCnt_q <= 5'h00;
    end else if (halfTick && state_q != adcc_pkg::ADCC_IDLE) begin
      halfCnt_q <= halfCnt_q + 5'h01;
    end
  end

  always_ff @(posedge clock) begin
    if (rst || startConv) begin
      trial_q <= `ADCC_TRIAL_RST;
      bitMask_q <= `ADCC_TRIAL_RST;
    end else if (decideTick) begin
      trial_q <= keptTrial | (bitMask_q >> 1);
      bitMask_q <= bitMask_q >> 1;
    end
  end

  assign dacTrial = trial_q;
  // switch opens with the start and closes when idle again
  assign holdCapDisconnect = (state_q != adcc_pkg::ADCC_IDLE);

  // no reset here: contents stay unknown until the first conversion
  always_ff @(posedge clock) begin
    if (finishConv) begin
      result_q <= keptTrial;
    end
  end

  // ********************************************************
  // interrupt
  // ********************************************************
  // a done event in the clearing cycle wins over the clear
  always_ff @(posedge clock) begin
    if (rst) begin
      doneFlag_q <= 1'b0;
    end else if (finishConv) begin
      doneFlag_q <= 1'b1;
    end else if (wrAccess && paddr == ADDR_W'(`ADCC_ADDR_IRQ_STATUS) && pwdata[`ADCC_IRQ_DONE]) begin
      doneFlag_q <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      doneMask_q <= 1'b0;
      globalEn_q <= 1'b0;
    end else if (wrAccess && paddr == ADDR_W'(`ADCC_ADDR_IRQ_MASK)) begin
      doneMask_q <= pwdata[`ADCC_IRQ_DONE];
      globalEn_q <= pwdata[`ADCC_IRQ_GLOBAL];
    end
  end

  // level output, drops as soon as software clears the flag
  assign irq = doneFlag_q && doneMask_q && globalEn_q;

endmodule
`default_nettype wire

//--- adcc_conversion_control_properties.sv
// assertions on the ports of the a/d conversion control block
// assumes bind onto adcc_conversion_control, one clock, synchronous reset
`timescale 1ns/10ps
`default_nettype none
`include "adcc_defines.svh"

module adcc_conversion_control_properties #(
  parameter int ADDR_W = 12
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pslverr,
  input wire logic irq,
  input wire logic sleepMode,
  input wire logic [2:0] channelSelect,
  input wire logic holdCapDisconnect,
  input wire logic converterPowered
);
  // ********************************
  // helpers
  // ********************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  logic ctlWr;
  logic maskWr;
  logic startReq;
  assign ctlWr = psel && penable && pwrite && paddr == ADDR_W'(`ADCC_ADDR_CONTROL);
  assign maskWr = psel && penable && pwrite && paddr == ADDR_W'(`ADCC_ADDR_IRQ_MASK);
  // start needs power already on: go in the power-up write is ignored
  assign startReq = ctlWr && pwdata[2] && pwdata[0] && converterPowered && !holdCapDisconnect;

  // ********************************
  // properties
  // ********************************
  conv_start_a: assert property (startReq |=> holdCapDisconnect)
    else $error("conversion did not start on go");
  conv_len2_a: assert property (startReq && pwdata[7:6] == 2'b00 && !sleepMode
    |=> holdCapDisconnect [*8] ##11 holdCapDisconnect ##1 !holdCapDisconnect)
    else $error("two-period conversion length wrong");
  conv_len8_a: assert property (startReq && pwdata[7:6] == 2'b01 && !sleepMode
    |=> holdCapDisconnect [*8] ##68 holdCapDisconnect ##1 !holdCapDisconnect)
    else $error("eight-period conversion length wrong");
  power_hold_a: assert property (holdCapDisconnect |-> converterPowered)
    else $error("converting while powered off");
  ctl_fields_a: assert property (ctlWr |=> converterPowered == $past(pwdata[0])
    && channelSelect == $past(pwdata[5:3]))
    else $error("control fields not taken");
  irq_cause_a: assert property ($rose(irq) |-> $fell(holdCapDisconnect) || $past(maskWr))
    else $error("interrupt without completion");
  abort_off_a: assert property (ctlWr && !pwdata[0] |=> !holdCapDisconnect && !converterPowered)
    else $error("power off did not abort");
  reset_vals_a: assert property ($fell(rst) |-> !holdCapDisconnect && !converterPowered
    && !irq && channelSelect == 3'h0)
    else $error("outputs not at reset values");

  cover property ($fell(holdCapDisconnect) && !$past(ctlWr));
  cover property ($rose(irq));
  cover property (pslverr);
endmodule

bind adcc_conversion_control adcc_conversion_control_properties #(.ADDR_W(ADDR_W)) u_props (
  .clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pslverr(pslverr), .irq(irq), .sleepMode(sleepMode),
  .channelSelect(channelSelect), .holdCapDisconnect(holdCapDisconnect),
  .converterPowered(converterPowered));
`default_nettype wire

//--- testbench.sv
// self-checking bench for the a/d conversion control block
// assumes apb with zero wait states and a comparator modelled from dacTrial
`timescale 1ns/10ps
`default_nettype none
`include "adcc_defines.svh"

module testbench;
  logic clock, rst, psel, penable, pwrite, pready, pslverr, irq, sleepMode, compAboveIn;
  logic holdCapDisconnect, converterPowered, lastErr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [5:0] portPinIn, portPinOut, portPinOe, pins;
  logic [2:0] channelSelect;
  logic [7:0] dacTrial, level;
  int mismatches = 0;
  int compares = 0;
  // acquisition wait: 13 us at the 100 ns clock
  localparam int ACQ_CYCLES = 130;

  adcc_conversion_control dut (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .sleepMode(sleepMode), .compAboveIn(compAboveIn),
    .portPinIn(portPinIn), .portPinOut(portPinOut), .portPinOe(portPinOe),
    .channelSelect(channelSelect), .holdCapDisconnect(holdCapDisconnect), .dacTrial(dacTrial),
    .converterPowered(converterPowered));

  always #50 clock = ~clock;
  // ideal analog input: exact level compared against the trial code
  always @(posedge clock) compAboveIn <= (level >= dacTrial);

  // ********************************
  // tasks
  // ********************************
  task automatic test_done;
    if (mismatches == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clock);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      mismatches++;
      test_done();
    end
    r = prdata;
    lastErr = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(r, exp);
  endtask

  function automatic int halfOf(input int s);
    case (s)
      0: return `ADCC_TOSC_DIV0 / 2;
      1: return `ADCC_TOSC_DIV1 / 2;
      2: return `ADCC_TOSC_DIV2 / 2;
      default: return `ADCC_RC_HALF_CYCLES;
    endcase
  endfunction

  function automatic logic [5:0] analogOf(input int cfg);
    case (cfg)
      0: return 6'h2F;
      1: return 6'h0F;
      2: return 6'h07;
      3: return 6'h03;
      4: return 6'h01;
      default: return 6'h00;
    endcase
  endfunction

  // power first, then go: go in the power-up write is ignored
  task automatic conv(input int s, input int ch);
    int n = 0;
    logic [31:0] c;
    c = 32'((s << 6) | (ch << 3) | 1);
    apb(1'b1, `ADCC_ADDR_CONTROL, c);
    repeat (ACQ_CYCLES) @(posedge clock);
    apb(1'b1, `ADCC_ADDR_CONTROL, c | 32'h4);
    while (n < 1000) begin
      @(posedge clock);
      if (holdCapDisconnect !== 1'b1) break;
      n++;
    end
    chk(32'(n), 32'(19 * halfOf(s)));
    if (n >= 1000) test_done();
    repeat (4 * halfOf(s)) @(posedge clock);
    rdc(`ADCC_ADDR_CONTROL, c);
  endtask

  // ********************************
  // main sequence
  // ********************************
  initial begin
    clock = 1'b0; rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
    pwdata = 32'h0; sleepMode = 1'b0; compAboveIn = 1'b0; portPinIn = 6'h00; level = 8'h00;
    void'($urandom(32'h8865));
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    rdc(`ADCC_ADDR_CONTROL, 32'h0);
    rdc(`ADCC_ADDR_PIN_CONFIG, 32'h0);
    rdc(`ADCC_ADDR_PORT_A_DIR, 32'h3F);
    apb(1'b0, 12'h100, 32'h0);
    chk({r[30:0], lastErr}, 32'h1);
    apb(1'b1, `ADCC_ADDR_PIN_CONFIG, 32'h0);
    apb(1'b1, `ADCC_ADDR_IRQ_MASK, 32'hC0);
    apb(1'b1, `ADCC_ADDR_IRQ_STATUS, 32'h40);
    for (int s = 0; s < 4; s++) begin
      level <= 8'($urandom);
      sleepMode <= (s == 3);
      conv(s, 0);
      sleepMode <= 1'b0;
      if (s >= 2) rdc(`ADCC_ADDR_RESULT, 32'(level));
      chk(32'(irq), 32'h1);
      rdc(`ADCC_ADDR_IRQ_STATUS, 32'h40);
      apb(1'b1, `ADCC_ADDR_IRQ_STATUS, 32'h40);
      @(posedge clock);
      chk(32'(irq), 32'h0);
    end
    apb(1'b1, `ADCC_ADDR_IRQ_MASK, 32'h40);
    conv(2, 0);
    chk(32'(irq), 32'h0);
    apb(1'b1, `ADCC_ADDR_IRQ_STATUS, 32'h40);
    apb(1'b1, `ADCC_ADDR_IRQ_MASK, 32'hC0);
    apb(1'b1, `ADCC_ADDR_PORT_A_DIR, 32'h3D);
    for (int v = 0; v < 2; v++) begin
      apb(1'b1, `ADCC_ADDR_PORT_A, 32'(v * 2));
      @(posedge clock);
      chk({portPinOe, portPinOut}, 32'(12'h080 | (v * 2)));
      conv(2, 1);
      rdc(`ADCC_ADDR_RESULT, v ? 32'hFF : 32'h0);
    end
    apb(1'b1, `ADCC_ADDR_PORT_A_DIR, 32'h3F);
    apb(1'b1, `ADCC_ADDR_PIN_CONFIG, 32'h5);
    level <= 8'($urandom);
    conv(3, 0);
    rdc(`ADCC_ADDR_RESULT, 32'(level));
    pins = 6'($urandom);
    portPinIn <= pins;
    for (int cfg = 0; cfg < 8; cfg++) begin
      apb(1'b1, `ADCC_ADDR_PIN_CONFIG, 32'(cfg));
      rdc(`ADCC_ADDR_PORT_A, 32'(pins & ~analogOf(cfg)));
    end
    apb(1'b1, `ADCC_ADDR_IRQ_STATUS, 32'h40);
    apb(1'b1, `ADCC_ADDR_CONTROL, 32'h81);
    apb(1'b1, `ADCC_ADDR_CONTROL, 32'h85);
    repeat (5) @(posedge clock);
    apb(1'b1, `ADCC_ADDR_CONTROL, 32'h80);
    repeat (400) @(posedge clock);
    chk({holdCapDisconnect, converterPowered}, 32'h0);
    rdc(`ADCC_ADDR_IRQ_STATUS, 32'h0);
    apb(1'b1, `ADCC_ADDR_CONTROL, 32'h81);
    apb(1'b1, `ADCC_ADDR_CONTROL, 32'h85);
    repeat (10) @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    chk({holdCapDisconnect, irq}, 32'h0);
    rdc(`ADCC_ADDR_CONTROL, 32'h0);
    rdc(`ADCC_ADDR_IRQ_MASK, 32'h0);
    test_done();
  end
endmodule
`default_nettype wire
